// ### hw/hrc_pkg.sv
// Constants, register map and state codes for the HDLC receiver control block
// How it works
// - Three receivers per channel share one window chosen by two bank-select bits.
// - Address match disabled: every received frame is stored in the FIFO.
// - Match, full mode: first byte all ones, primary or secondary pattern.
// - Match, mask mode: only upper six bits compared against ones and patterns.
// - Restart drops current frame, empties FIFO, clears interrupts, hunts for flag.
// - Restart bit self-clears after one full clock.
// - Enable low keeps receiver idle with FIFO and interrupt flags cleared.
// - Enable high starts opening-flag hunt at once.
// - Enable toggled off and on abandons frame, empties FIFO, restarts hunt.
// - Interrupt enable gates summary flag rising edge onto the low-active pin.
// - Interrupt control holds enable in bit 7, threshold in bits 6..0, reset zero.
// - FIFO fill above threshold raises interrupt once, rearmed when empty; zero means 128.
// - Summary flag set by link up, packet, link change, threshold, overwrite; read clears.
// - Pattern bit 0 is the first serially received address bit.
package hrc_pkg;
    localparam int NUM_LANES  = 3;
    localparam int FIFO_DEPTH = 128;
    localparam int ENTRY_W    = 11;

    localparam logic [7:0] ADDR_COMMON = 8'h0A;
    localparam logic [7:0] ADDR_CFG    = 8'h48;
    localparam logic [7:0] ADDR_INTC   = 8'h49;
    localparam logic [7:0] ADDR_STAT   = 8'h4A;
    localparam logic [7:0] ADDR_DATA   = 8'h4B;
    localparam logic [7:0] ADDR_PA     = 8'h4C;
    localparam logic [7:0] ADDR_SA     = 8'h4D;

    localparam int SEL_HI   = 7;
    localparam int SEL_LO   = 6;
    localparam int CFG_MEN  = 3;
    localparam int CFG_MM   = 2;
    localparam int CFG_TR   = 1;
    localparam int CFG_EN   = 0;
    localparam int INTC_IE  = 7;
    localparam int INTC_THR = 6;

    localparam logic [1:0] SEL_RST  = 2'h0;
    localparam logic [3:0] CFG_RST  = 4'h0;
    localparam logic [7:0] INTC_RST = 8'h00;
    localparam logic [7:0] PAT_RST  = 8'hFF;

    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_HI6  = 8'hFC;
    localparam logic [2:0] STUFF_ONES = 3'h5;
    localparam logic [2:0] ABORT_ONES = 3'h6;
    localparam logic [2:0] ONES_MAX   = 3'h7;
    localparam logic [7:0] THR_ZERO   = 8'h80;

    localparam logic [2:0] PBS_NORMAL = 3'h0;
    localparam logic [2:0] PBS_UP     = 3'h1;
    localparam logic [2:0] PBS_DOWN   = 3'h2;
    localparam logic [2:0] PBS_LAST   = 3'h4;

    typedef enum logic [3:0] {
        ST_HUNT = 4'h1,
        ST_IDLE = 4'h2,
        ST_DATA = 4'h4,
        ST_SKIP = 4'h8
    } hrc_state_t;
endpackage

// ### hw/hrc_match.sv
// First-byte address filter of one receiver
`timescale 1ns/1ps
module hrc_match (
    input  wire logic [7:0] first_byte,
    input  wire logic [7:0] pattern_a,
    input  wire logic [7:0] pattern_b,
    input  wire logic       match_en,
    input  wire logic       mask_mode,
    output logic            accept
);
    logic [7:0] mask;
    logic       hit;

    always_comb begin
        mask   = mask_mode ? hrc_pkg::MASK_HI6 : hrc_pkg::MASK_FULL;
        hit    = ((first_byte & mask) == mask)
               | (((first_byte ^ pattern_a) & mask) == 8'h00)
               | (((first_byte ^ pattern_b) & mask) == 8'h00);
        accept = !match_en | hit;
    end
endmodule

// ### hw/hrc_fifo.sv
// Flip-flop FIFO of 11-bit entries (3 status bits and a byte) with fill count and flush
`timescale 1ns/1ps
module hrc_fifo #(
    parameter int WIDTH = hrc_pkg::ENTRY_W,
    parameter int DEPTH = hrc_pkg::FIFO_DEPTH
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   flush,
    input  wire logic                   push,
    input  wire logic [WIDTH-1:0]       din,
    input  wire logic                   pop,
    output logic      [WIDTH-1:0]       dout,
    output logic      [$clog2(DEPTH):0] count,
    output logic                        empty,
    output logic                        full
);
    localparam int AW = $clog2(DEPTH);

    if ((1 << AW) != DEPTH) begin : g_chk
        $error("FIFO depth must be a power of two");
    end

    logic [DEPTH-1:0][WIDTH-1:0] mem_q, mem_d;
    logic [AW-1:0]               wptr_q, wptr_d, rptr_q, rptr_d;
    logic [AW:0]                 cnt_q, cnt_d;
    logic                        do_push, do_pop;

    assign count = cnt_q;
    assign empty = (cnt_q == '0);
    assign full  = (cnt_q == (AW+1)'(DEPTH));
    assign dout  = mem_q[rptr_q];

    always_comb begin
        do_push = push && !full;
        do_pop  = pop && !empty;
        mem_d   = mem_q;
        wptr_d  = wptr_q;
        rptr_d  = rptr_q;
        cnt_d   = cnt_q;
        if (flush) begin
            wptr_d = '0;
            rptr_d = '0;
            cnt_d  = '0;
        end else begin
            if (do_push) begin
                mem_d[wptr_q] = din;
                wptr_d        = wptr_q + 1'b1;
            end
            if (do_pop) begin
                rptr_d = rptr_q + 1'b1;
            end
            cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q  <= '0;
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end else begin
            mem_q  <= mem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
        end
    end
endmodule

// ### hw/hrc_top.sv
// Three HDLC receivers with address filter, FIFO, interrupt control and host registers
`timescale 1ns/1ps
module hrc_top #(
    parameter int LANES = hrc_pkg::NUM_LANES,
    parameter int DEPTH = hrc_pkg::FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       host_addr,
    input  wire logic             host_wr,
    input  wire logic             host_rd,
    input  wire logic [7:0]       host_wdata,
    output logic      [7:0]       host_rdata,
    input  wire logic [LANES-1:0] rx_bit,
    input  wire logic [LANES-1:0] rx_bit_en,
    output logic                  int_n
);
    localparam int CW = $clog2(DEPTH) + 1;

    if (LANES < 1 || LANES > 3 || DEPTH < 128) begin : g_chk
        $error("Need 1 to 3 receivers and a FIFO of at least 128 entries");
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic [1:0]                  sel_q, sel_d;
    logic [LANES-1:0][3:0]       cfg_q, cfg_d;
    logic [LANES-1:0][7:0]       intc_q, intc_d, pa_q, pa_d, sa_q, sa_d;
    logic [7:0]                  rdata_q, rdata_d;
    logic                        int_n_q, int_n_d;
    logic [LANES-1:0]            fe_v, ovr_v, cols_v, pkin_v, receiver_irq_pending_v, pend_d_v;
    logic [LANES-1:0][2:0]       pbs_v;
    logic [LANES-1:0][7:0]       dout_v;
    logic [LANES-1:0]            bank_v;

    assign host_rdata = rdata_q;
    assign int_n      = int_n_q;

    // Host register file; lane registers reach only the bank that is selected
    always_comb begin
        sel_d   = sel_q;
        cfg_d   = cfg_q;
        intc_d  = intc_q;
        pa_d    = pa_q;
        sa_d    = sa_q;
        rdata_d = rdata_q;
        for (int k = 0; k < LANES; k++) begin
            cfg_d[k][hrc_pkg::CFG_TR] = 1'b0;
        end
        if (host_wr) begin
            if (host_addr == hrc_pkg::ADDR_COMMON) begin
                sel_d = host_wdata[hrc_pkg::SEL_HI:hrc_pkg::SEL_LO];
            end
            for (int k = 0; k < LANES; k++) begin
                if (bank_v[k]) begin
                    case (host_addr)
                        hrc_pkg::ADDR_CFG:  cfg_d[k]  = host_wdata[3:0];
                        hrc_pkg::ADDR_INTC: intc_d[k] = host_wdata;
                        hrc_pkg::ADDR_PA:   pa_d[k]   = host_wdata;
                        hrc_pkg::ADDR_SA:   sa_d[k]   = host_wdata;
                        default: ;
                    endcase
                end
            end
        end
        if (host_rd) begin
            rdata_d = 8'h00;
            if (host_addr == hrc_pkg::ADDR_COMMON) begin
                rdata_d = {sel_q, 6'h00};
            end
            for (int k = 0; k < LANES; k++) begin
                if (bank_v[k]) begin
                    case (host_addr)
                        hrc_pkg::ADDR_CFG:  rdata_d = {4'h0, cfg_q[k]};
                        hrc_pkg::ADDR_INTC: rdata_d = intc_q[k];
                        hrc_pkg::ADDR_STAT: rdata_d = {fe_v[k], ovr_v[k], cols_v[k], pkin_v[k], pbs_v[k], receiver_irq_pending_v[k]};
                        hrc_pkg::ADDR_DATA: rdata_d = dout_v[k];
                        hrc_pkg::ADDR_PA:   rdata_d = pa_q[k];
                        hrc_pkg::ADDR_SA:   rdata_d = sa_q[k];
                        default: ;
                    endcase
                end
            end
        end
        int_n_d = ~|pend_d_v;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q   <= hrc_pkg::SEL_RST;
            cfg_q   <= {LANES{hrc_pkg::CFG_RST}};
            intc_q  <= {LANES{hrc_pkg::INTC_RST}};
            pa_q    <= {LANES{hrc_pkg::PAT_RST}};
            sa_q    <= {LANES{hrc_pkg::PAT_RST}};
            rdata_q <= 8'h00;
            int_n_q <= 1'b1;
        end else begin
            sel_q   <= sel_d;
            cfg_q   <= cfg_d;
            intc_q  <= intc_d;
            pa_q    <= pa_d;
            sa_q    <= sa_d;
            rdata_q <= rdata_d;
            int_n_q <= int_n_d;
        end
    end

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        hrc_pkg::hrc_state_t st_q, st_d;
        logic [7:0]  sh_q, sh_d, byte_q, byte_d, held_q, held_d, sh_n, byte_n, thr_val;
        logic [2:0]  ones_q, ones_d, cnt_q, cnt_d, pbs_q, pbs_d;
        logic        link_q, link_d, held_v_q, held_v_d;
        logic        ovr_q, ovr_d, cols_q, cols_d, pkin_q, pkin_d, receiver_irq_pending_q, receiver_irq_pending_d;
        logic        thr_q, thr_d, pend_q, pend_d;
        logic        en, clear, bit_ok, flag_hit, stuff, abort_hit, accept, exceed;
        logic        push, pop, ovf, ev_any, ev_first, ev_cols, ev_pkt, stat_rd;
        logic        fifo_empty, fifo_full;
        logic [hrc_pkg::ENTRY_W-1:0] push_data, fifo_dout;
        logic [CW-1:0]               fifo_cnt;

        assign bank_v[i]   = (sel_q == 2'(i));
        assign en          = cfg_q[i][hrc_pkg::CFG_EN];
        assign clear       = !en || cfg_q[i][hrc_pkg::CFG_TR];
        assign bit_ok      = rx_bit_en[i] && en;
        assign sh_n        = {rx_bit[i], sh_q[7:1]};
        assign byte_n      = {rx_bit[i], byte_q[7:1]};
        assign flag_hit    = bit_ok && (sh_n == hrc_pkg::FLAG_BYTE);
        assign stuff       = bit_ok && !rx_bit[i] && (ones_q == hrc_pkg::STUFF_ONES);
        assign abort_hit   = bit_ok && rx_bit[i] && (ones_q == hrc_pkg::ABORT_ONES);
        assign stat_rd     = host_rd && bank_v[i] && (host_addr == hrc_pkg::ADDR_STAT);
        assign pop         = host_rd && bank_v[i] && (host_addr == hrc_pkg::ADDR_DATA) && !fifo_empty;
        assign ovf         = push && fifo_full;
        assign thr_val     = (intc_q[i][hrc_pkg::INTC_THR:0] == 7'h00) ? hrc_pkg::THR_ZERO
                           : {1'b0, intc_q[i][hrc_pkg::INTC_THR:0]};
        assign exceed      = (CW'(fifo_cnt) > CW'(thr_val));
        assign fe_v[i]     = fifo_empty;
        assign ovr_v[i]    = ovr_q;
        assign cols_v[i]   = cols_q;
        assign pkin_v[i]   = pkin_q;
        assign receiver_irq_pending_v[i]   = receiver_irq_pending_q;
        assign pbs_v[i]    = pbs_q;
        assign dout_v[i]   = fifo_dout[7:0];
        assign pend_d_v[i] = pend_d;

        hrc_match u_match (
            .first_byte (byte_n),
            .pattern_a  (pa_q[i]),
            .pattern_b  (sa_q[i]),
            .match_en   (cfg_q[i][hrc_pkg::CFG_MEN]),
            .mask_mode  (cfg_q[i][hrc_pkg::CFG_MM]),
            .accept     (accept)
        );

        hrc_fifo #(.WIDTH(hrc_pkg::ENTRY_W), .DEPTH(DEPTH)) u_fifo (
            .mclk  (mclk),
            .rst_n (rst_n),
            .flush (clear || ovf),
            .push  (push && !ovf),
            .din   (push_data),
            .pop   (pop),
            .dout  (fifo_dout),
            .count (fifo_cnt),
            .empty (fifo_empty),
            .full  (fifo_full)
        );

        // Bit-level deframer: flag hunt, destuffing, byte assembly and first-byte filter
        always_comb begin
            st_d      = st_q;
            sh_d      = sh_q;
            byte_d    = byte_q;
            held_d    = held_q;
            held_v_d  = held_v_q;
            ones_d    = ones_q;
            cnt_d     = cnt_q;
            link_d    = link_q;
            push      = 1'b0;
            push_data = '0;
            ev_first  = 1'b0;
            ev_cols   = 1'b0;
            ev_pkt    = 1'b0;
            if (clear) begin
                st_d     = hrc_pkg::ST_HUNT;
                sh_d     = 8'h00;
                ones_d   = 3'h0;
                cnt_d    = 3'h0;
                held_v_d = 1'b0;
                link_d   = 1'b0;
            end else if (bit_ok) begin
                sh_d   = sh_n;
                ones_d = !rx_bit[i] ? 3'h0 : (ones_q == hrc_pkg::ONES_MAX) ? ones_q : ones_q + 3'h1;
                if (abort_hit) begin
                    if (link_q) begin
                        push      = 1'b1;
                        push_data = {hrc_pkg::PBS_DOWN, 8'h00};
                        ev_cols   = 1'b1;
                    end
                    link_d   = 1'b0;
                    held_v_d = 1'b0;
                    st_d     = hrc_pkg::ST_HUNT;
                end else if (flag_hit) begin
                    cnt_d = 3'h0;
                    if (st_q == hrc_pkg::ST_DATA && held_v_q) begin
                        push      = 1'b1;
                        push_data = {hrc_pkg::PBS_LAST, held_q};
                        ev_pkt    = 1'b1;
                    end else if (!link_q) begin
                        push      = 1'b1;
                        push_data = {hrc_pkg::PBS_UP, 8'h00};
                        ev_first  = 1'b1;
                        ev_cols   = 1'b1;
                        link_d    = 1'b1;
                    end
                    held_v_d = 1'b0;
                    st_d     = hrc_pkg::ST_IDLE;
                end else if (st_q != hrc_pkg::ST_HUNT && !stuff) begin
                    byte_d = byte_n;
                    cnt_d  = cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        case (st_q)
                            hrc_pkg::ST_IDLE: begin
                                st_d     = accept ? hrc_pkg::ST_DATA : hrc_pkg::ST_SKIP;
                                held_d   = byte_n;
                                held_v_d = accept;
                            end
                            hrc_pkg::ST_DATA: begin
                                push      = held_v_q;
                                push_data = {hrc_pkg::PBS_NORMAL, held_q};
                                held_d    = byte_n;
                                held_v_d  = 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
            end
        end

        // Sticky status flags; an event wins over a status-read clear in the same cycle, but clear wins over any event
        always_comb begin
            ev_any = ev_first || ev_cols || ev_pkt || ovf || (exceed && !thr_q);
            thr_d  = exceed || (thr_q && !fifo_empty);
            ovr_d  = ovf || (ovr_q && !stat_rd);
            cols_d = ev_cols || (cols_q && !stat_rd && !ovf);
            pkin_d = (ev_pkt && !ovf) || (pkin_q && !stat_rd && !ovf);
            receiver_irq_pending_d = ev_any || (receiver_irq_pending_q && !stat_rd);
            pbs_d  = pop ? fifo_dout[10:8] : pbs_q;
            pend_d = intc_q[i][hrc_pkg::INTC_IE] && ((receiver_irq_pending_d && !receiver_irq_pending_q) || (pend_q && receiver_irq_pending_d));
            if (clear) begin
                thr_d  = 1'b0;
                ovr_d  = 1'b0;
                cols_d = 1'b0;
                pkin_d = 1'b0;
                receiver_irq_pending_d = 1'b0;
                pend_d = 1'b0;
            end
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                st_q     <= hrc_pkg::ST_HUNT;
                sh_q     <= 8'h00;
                byte_q   <= 8'h00;
                held_q   <= 8'h00;
                held_v_q <= 1'b0;
                ones_q   <= 3'h0;
                cnt_q    <= 3'h0;
                link_q   <= 1'b0;
                thr_q    <= 1'b0;
                ovr_q    <= 1'b0;
                cols_q   <= 1'b0;
                pkin_q   <= 1'b0;
                receiver_irq_pending_q   <= 1'b0;
                pbs_q    <= 3'h0;
                pend_q   <= 1'b0;
            end else begin
                st_q     <= st_d;
                sh_q     <= sh_d;
                byte_q   <= byte_d;
                held_q   <= held_d;
                held_v_q <= held_v_d;
                ones_q   <= ones_d;
                cnt_q    <= cnt_d;
                link_q   <= link_d;
                thr_q    <= thr_d;
                ovr_q    <= ovr_d;
                cols_q   <= cols_d;
                pkin_q   <= pkin_d;
                receiver_irq_pending_q   <= receiver_irq_pending_d;
                pbs_q    <= pbs_d;
                pend_q   <= pend_d;
            end
        end

        property p_store_all;
            (!clear && bit_ok && !flag_hit && !abort_hit && !stuff && st_q == hrc_pkg::ST_IDLE
             && cnt_q == 3'h7 && !cfg_q[i][hrc_pkg::CFG_MEN]) |=> (st_q == hrc_pkg::ST_DATA);
        endproperty
        a_store_all: assert property (p_store_all) else $error("Frame dropped with matching off");

        property p_full_reject;
            (cfg_q[i][hrc_pkg::CFG_MEN] && !cfg_q[i][hrc_pkg::CFG_MM] && byte_n != 8'hFF
             && byte_n != pa_q[i] && byte_n != sa_q[i]) |-> !accept;
        endproperty
        a_full_reject: assert property (p_full_reject) else $error("Unmatched first byte accepted");

        property p_mask_accept;
            (cfg_q[i][hrc_pkg::CFG_MEN] && cfg_q[i][hrc_pkg::CFG_MM] && byte_n[7:2] == sa_q[i][7:2]) |-> accept;
        endproperty
        a_mask_accept: assert property (p_mask_accept) else $error("Masked match refused");

        property p_restart;
            cfg_q[i][hrc_pkg::CFG_TR] |=> (st_q == hrc_pkg::ST_HUNT && fifo_empty && !receiver_irq_pending_q && !pend_q);
        endproperty
        a_restart: assert property (p_restart) else $error("Restart left state behind");

        property p_tr_clear;
            (cfg_q[i][hrc_pkg::CFG_TR] && !(host_wr && bank_v[i] && host_addr == hrc_pkg::ADDR_CFG))
            |=> !cfg_q[i][hrc_pkg::CFG_TR];
        endproperty
        a_tr_clear: assert property (p_tr_clear) else $error("Restart bit did not self-clear");

        property p_disabled;
            (!en)[*2] |-> (st_q == hrc_pkg::ST_HUNT && fifo_empty && !receiver_irq_pending_q && !ovr_q && !cols_q);
        endproperty
        a_disabled: assert property (p_disabled) else $error("Disabled receiver not cleared");

        property p_irq_gate;
            (!clear && receiver_irq_pending_d && !receiver_irq_pending_q) |=> (pend_q == $past(intc_q[i][hrc_pkg::INTC_IE]))
                                              && (!int_n || !$past(intc_q[i][hrc_pkg::INTC_IE]));
        endproperty
        a_irq_gate: assert property (p_irq_gate) else $error("Interrupt pin gating wrong");

        property p_thr_event;
            (!clear && exceed && !thr_q) |=> receiver_irq_pending_q ##1 (thr_q || fifo_empty || !en);
        endproperty
        a_thr_event: assert property (p_thr_event) else $error("Threshold did not raise interrupt");

        property p_skip;
            (st_q == hrc_pkg::ST_SKIP && !flag_hit && !abort_hit) |-> !push;
        endproperty
        a_skip: assert property (p_skip) else $error("Rejected frame stored");
    end
endmodule

// ### testbench/hrc_link_src.sv
// Serial bit source standing in for the receive framer of one lane
`timescale 1ns/1ps
module hrc_link_src (
    input  wire logic mclk,
    output logic      bit_o,
    output logic      en_o
);
    initial begin
        bit_o = 1'h1;
        en_o  = 1'h0;
    end
    // LSB first; between qualified bits the line shows the inverse of the last bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            bit_o = b[i];
            en_o  = 1'h1;
            @(negedge mclk);
            en_o  = 1'h0;
            bit_o = ~b[i];
        end
    endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the HDLC receiver control block
`timescale 1ns/1ps
module tb;
    logic       mclk       = 1'h0;
    logic       rst_n      = 1'h0;
    logic [7:0] host_addr  = 8'h00;
    logic       host_wr    = 1'h0;
    logic       host_rd    = 1'h0;
    logic [7:0] host_wdata = 8'h00;
    logic [7:0] host_rdata;
    logic       src_bit;
    logic       src_en;
    logic       int_n;
    int         fail_count = 0;
    int         tests_run  = 0;
    int         cycles     = 0;
    logic [7:0] s;
    always #5 mclk = ~mclk;
    hrc_top dut_u (.mclk(mclk), .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .rx_bit({2'h0, src_bit}),
        .rx_bit_en({2'h0, src_en}), .int_n(int_n));
    hrc_link_src lsrc_u (.mclk(mclk), .bit_o(src_bit), .en_o(src_en));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        host_addr  = a;
        host_wdata = d;
        host_wr    = 1'h1;
        @(negedge mclk);
        host_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        host_addr = a;
        host_rd   = 1'h1;
        @(negedge mclk);
        host_rd = 1'h0;
        d       = host_rdata;
    endtask
    // Disable then enable so each frame starts from a cleared receiver
    task automatic relink(input logic [7:0] cfg);
        wr(8'h48, 8'h00);
        wr(8'h48, cfg);
        rd(8'h4A, s);
    endtask
    task automatic run_frame(input logic [7:0] cfg, input logic [7:0] a, input logic [7:0] exp);
        relink(cfg);
        lsrc_u.send_byte(hrc_pkg::FLAG_BYTE);
        lsrc_u.send_byte(a);
        lsrc_u.send_byte(8'h21);
        lsrc_u.send_byte(hrc_pkg::FLAG_BYTE);
        repeat (4) @(negedge mclk);
        rd(8'h4A, s);
        check(s & 8'h91, exp);
        $display("frame test done: cfg %h first byte %h", cfg, a);
    endtask
    task automatic reg_test();
        rd(8'h48, s);
        check(s, 8'h00);
        rd(8'h49, s);
        check(s, 8'h00);
        rd(8'h4C, s);
        check(s, 8'hFF);
        rd(8'h50, s);
        check(s, 8'h00);
        wr(8'h0A, 8'h40);
        wr(8'h49, 8'h55);
        rd(8'h49, s);
        check(s, 8'h55);
        wr(8'h0A, 8'h00);
        rd(8'h49, s);
        check(s, 8'h00);
        $display("register test done");
    endtask
    task automatic irq_test();
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h80);
        relink(8'h01);
        lsrc_u.send_byte(hrc_pkg::FLAG_BYTE);
        repeat (3) @(negedge mclk);
        check({7'h0, int_n}, 8'h00);
        wr(8'h48, 8'h03);
        repeat (2) @(negedge mclk);
        check({7'h0, int_n}, 8'h01);
        rd(8'h48, s);
        check(s, 8'h01);
        rd(8'h4A, s);
        check(s & 8'h81, 8'h80);
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h00);
        relink(8'h01);
        lsrc_u.send_byte(hrc_pkg::FLAG_BYTE);
        repeat (3) @(negedge mclk);
        check({7'h0, int_n}, 8'h01);
        $display("interrupt test done");
    endtask
    // Threshold of one: the late-pushed address byte makes the fill two and fires the interrupt once
    task automatic thr_test();
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h01);
        relink(8'h01);
        lsrc_u.send_byte(hrc_pkg::FLAG_BYTE);
        rd(8'h4A, s);
        lsrc_u.send_byte(8'h12);
        lsrc_u.send_byte(8'h21);
        repeat (2) @(negedge mclk);
        rd(8'h4A, s);
        check(s & 8'h81, 8'h01);
        rd(8'h4A, s);
        check(s & 8'h81, 8'h00);
        rd(8'h4B, s);
        check(s, 8'h00);
        rd(8'h4B, s);
        check(s, 8'h12);
        rd(8'h4A, s);
        check(s & 8'h8F, 8'h80);
        $display("threshold test done");
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'h1;
        reg_test();
        wr(8'h4C, 8'h34);
        wr(8'h4D, 8'h56);
        run_frame(8'h01, 8'h12, 8'h11);
        run_frame(8'h09, 8'h12, 8'h01);
        run_frame(8'h09, 8'h34, 8'h11);
        run_frame(8'h09, 8'h56, 8'h11);
        run_frame(8'h09, 8'h35, 8'h01);
        run_frame(8'h0D, 8'h35, 8'h11);
        irq_test();
        thr_test();
        complete_run();
    end
endmodule
